// >>> core/pcrd_map.vh
// constants for the punched card row decoder
`ifndef PCRD_MAP_VH
`define PCRD_MAP_VH
// --------------------------------------------------------------
// card geometry
// --------------------------------------------------------------
`define PCRD_ROWS 4'd12
`define PCRD_LAST_ROW 4'd11
`define PCRD_COLS 7'd80
`define PCRD_ID_FIRST 7'd1
`define PCRD_ID_LAST 7'd16
`define PCRD_INFO_FIRST 7'd17
`define PCRD_INFO_LAST 7'd80
`define PCRD_BIN_LAST_WORD 5'd23
`define PCRD_OCT_LAST_WORD 5'd3
`define PCRD_OCT_CTRL_LAST 7'd24
`define PCRD_OCT_LAST_COL 7'd68
`define PCRD_OCT_LAST_DIGIT 4'd10
// --------------------------------------------------------------
// column vector bit positions (bit k holds the k-th row read)
// --------------------------------------------------------------
`define PCRD_BIT_Z12 11
`define PCRD_BIT_Z11 10
`define PCRD_BIT_Z0 9
`define PCRD_BIT_N8 1
`define PCRD_BIT_N4 5
`define PCRD_BIT_N3 6
// --------------------------------------------------------------
// card modes
// --------------------------------------------------------------
`define PCRD_MODE_TEXT 2'h0
`define PCRD_MODE_BIN 2'h1
`define PCRD_MODE_OCT 2'h2
// --------------------------------------------------------------
// character codes
// --------------------------------------------------------------
`define PCRD_CH_BLANK 8'h20
`define PCRD_CH_PLUS 8'h2B
`define PCRD_CH_MINUS 8'h2D
`define PCRD_CH_ZERO 8'h30
`define PCRD_CH_SEVEN 8'h37
`define PCRD_CH_A 8'h41
`define PCRD_CH_J 8'h4A
`define PCRD_CH_S 8'h53
`define PCRD_CH_SLASH 8'h2F
`define PCRD_CH_DOLLAR 8'h24
`define PCRD_CH_COMMA 8'h2C
`define PCRD_CH_STAR 8'h2A
`define PCRD_CH_PERCENT 8'h25
`endif

// >>> core/pcrd_col_decode.v
// column punch pattern to character decoder
`timescale 1ns/100ps
`default_nettype none
`include "pcrd_map.vh"
module pcrd_col_decode (
  input wire [11:0] col_bits,
  output reg [7:0] chr,
  output reg bad
);
  // --------------------------------------------------------------
  // working values
  // --------------------------------------------------------------
  reg [3:0] num_cnt; // count of numeric punches
  reg [3:0] num_val; // value of last numeric punch
  reg [1:0] zone_cnt; // count of zone punches
  reg pair83; // 8-3 numeric pair
  reg pair84; // 8-4 numeric pair
  integer i;

  // --------------------------------------------------------------
  // decode
  // --------------------------------------------------------------
  // one combinational pass over the twelve rows
  always @* begin
    num_cnt = 4'h0;
    num_val = 4'h0;
    chr = `PCRD_CH_BLANK;
    bad = 1'b0;
    // numeric row m sits at bit 9-m
    for (i = 1; i <= 9; i = i + 1) begin
      if (col_bits[9 - i]) begin
        num_cnt = num_cnt + 4'h1;
        num_val = i[3:0];
      end
    end
    zone_cnt = {1'b0, col_bits[`PCRD_BIT_Z12]} + {1'b0, col_bits[`PCRD_BIT_Z11]} +
               {1'b0, col_bits[`PCRD_BIT_Z0]};
    pair83 = (num_cnt == 4'h2) && col_bits[`PCRD_BIT_N8] && col_bits[`PCRD_BIT_N3];
    pair84 = (num_cnt == 4'h2) && col_bits[`PCRD_BIT_N8] && col_bits[`PCRD_BIT_N4];
    if (zone_cnt > 2'h1) begin
      bad = 1'b1; // two zones never form a character
    end else if (num_cnt == 4'h0) begin
      // lone zone punches
      if (col_bits[`PCRD_BIT_Z12])
        chr = `PCRD_CH_PLUS;
      else if (col_bits[`PCRD_BIT_Z11])
        chr = `PCRD_CH_MINUS;
      else if (col_bits[`PCRD_BIT_Z0])
        chr = `PCRD_CH_ZERO;
    end else if (num_cnt == 4'h1) begin
      // digits and letters
      if (col_bits[`PCRD_BIT_Z12])
        chr = `PCRD_CH_A + {4'h0, num_val} - 8'h01;
      else if (col_bits[`PCRD_BIT_Z11])
        chr = `PCRD_CH_J + {4'h0, num_val} - 8'h01;
      else if (col_bits[`PCRD_BIT_Z0])
        chr = (num_val == 4'h1) ? `PCRD_CH_SLASH : (`PCRD_CH_S + {4'h0, num_val} - 8'h02);
      else
        chr = `PCRD_CH_ZERO + {4'h0, num_val};
    end else if (pair83) begin
      // 8-3 specials
      if (col_bits[`PCRD_BIT_Z12])
        bad = 1'b1;
      else if (col_bits[`PCRD_BIT_Z11])
        chr = `PCRD_CH_DOLLAR;
      else if (col_bits[`PCRD_BIT_Z0])
        chr = `PCRD_CH_COMMA;
      else
        chr = `PCRD_CH_PLUS;
    end else if (pair84) begin
      // 8-4 specials
      if (col_bits[`PCRD_BIT_Z12])
        bad = 1'b1;
      else if (col_bits[`PCRD_BIT_Z11])
        chr = `PCRD_CH_STAR;
      else if (col_bits[`PCRD_BIT_Z0])
        chr = `PCRD_CH_PERCENT;
      else
        chr = `PCRD_CH_MINUS;
    end else begin
      bad = 1'b1; // any other pattern
    end
    if (bad)
      chr = `PCRD_CH_BLANK; // undefined code reads as blank
  end
endmodule
`default_nettype wire

// >>> core/pcrd_decoder.v
// punched card row decoder: card image to host words and characters
`timescale 1ns/100ps
`default_nettype none
`include "pcrd_map.vh"
// Function
// - each position one bit, punched is one
// - lone numeric punch gives its digit
// - zone plus numeric punch gives a letter, except 0-1 which gives a slash
// - eight special codes from lone 12/11 zones and 8-3, 8-4 pairs
// - columns 17 to 80 reach host (17 to 68 on octonary cards), columns 1 to 16 only as id text
// - left word 17-48, right word 49-80
// - binary card yields at most 24 words
// - binary info raw, identification read as text
// - octonary card gives four octal word subfields
// - words go 9-row first, left before right
// - octonary control columns give first word address
module pcrd_decoder (
  input wire clk,
  input wire srst,
  input wire row_valid,
  output wire row_ready,
  input wire [79:0] row_data,
  input wire [1:0] card_mode,
  output reg chr_valid_reg,
  input wire chr_ready,
  output reg [7:0] chr_data_reg,
  output reg [6:0] chr_col_reg,
  output reg chr_bad_reg,
  output reg word_valid_reg,
  input wire word_ready,
  output reg [31:0] word_data_reg,
  output reg [23:0] word_addr_reg,
  output reg word_bad_reg,
  output wire card_busy
);
  // --------------------------------------------------------------
  // states
  // --------------------------------------------------------------
  localparam [1:0] ST_LOAD = 2'h0; // taking rows
  localparam [1:0] ST_CHAR = 2'h1; // column character scan
  localparam [1:0] ST_OCT = 2'h2; // octal subfield scan
  localparam [1:0] ST_WORD = 2'h3; // word delivery

  // --------------------------------------------------------------
  // storage and control
  // --------------------------------------------------------------
  reg [79:0] card_mem [0:11]; // rows, index 0 is the 9-row
  reg [31:0] oct_mem [0:3]; // assembled octal words
  reg [1:0] state_reg; // sequencer state
  reg [3:0] row_cnt_reg; // rows taken so far
  reg [1:0] mode_reg; // mode caught with the first row
  reg [6:0] col_reg; // column under scan, 1 based
  reg [4:0] wcnt_reg; // word counter
  reg [3:0] dig_cnt_reg; // digit within octal word
  reg [23:0] loc_reg; // octonary first word location
  reg [31:0] acc_reg; // octal word accumulator
  reg acc_bad_reg; // octal word error
  reg [3:0] oct_bad_reg; // error per octal word
  reg [11:0] col_bits; // punches of the scanned column
  reg [6:0] bit_idx; // row bit index of the column
  wire [7:0] dec_chr; // decoded character
  wire dec_bad; // undefined code
  wire dig_ok; // column is an octal digit
  wire [2:0] dig; // octal digit value
  wire chr_free; // character slot can load
  wire word_free; // word slot can load
  integer k;

  // rows are taken only once every result of the last card has been handed over
  assign row_ready = (state_reg == ST_LOAD) && !chr_valid_reg && !word_valid_reg;
  assign card_busy = !row_ready;
  assign chr_free = !chr_valid_reg || chr_ready;
  assign word_free = !word_valid_reg || word_ready;
  assign dig_ok = !dec_bad && (dec_chr >= `PCRD_CH_ZERO) && (dec_chr <= `PCRD_CH_SEVEN);
  assign dig = dec_chr[2:0];

  // --------------------------------------------------------------
  // column gather
  // --------------------------------------------------------------
  // column c sits at row bit 80-c, one punch per bit
  always @* begin
    bit_idx = `PCRD_COLS - col_reg;
    for (k = 0; k < 12; k = k + 1)
      col_bits[k] = card_mem[k][bit_idx];
  end

  // character decoder, shared by text and octal scans
  pcrd_col_decode u_dec (
    .col_bits(col_bits),
    .chr(dec_chr),
    .bad(dec_bad)
  );

  // --------------------------------------------------------------
  // row capture
  // --------------------------------------------------------------
  // rows arrive 9-row first; stored as bits without interpretation
  always @(posedge clk) begin
    if (row_valid && row_ready)
      card_mem[row_cnt_reg] <= row_data;
  end

  // --------------------------------------------------------------
  // octal word store
  // --------------------------------------------------------------
  always @(posedge clk) begin
    if (state_reg == ST_OCT && col_reg > `PCRD_OCT_CTRL_LAST && dig_cnt_reg == `PCRD_OCT_LAST_DIGIT)
      oct_mem[wcnt_reg[1:0]] <= {acc_reg[28:0], dig};
  end

  // --------------------------------------------------------------
  // sequencer
  // --------------------------------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      state_reg <= ST_LOAD;
      row_cnt_reg <= 4'h0;
      mode_reg <= `PCRD_MODE_TEXT;
      col_reg <= `PCRD_INFO_FIRST;
      wcnt_reg <= 5'h00;
      dig_cnt_reg <= 4'h0;
      loc_reg <= 24'h000000;
      acc_reg <= 32'h00000000;
      acc_bad_reg <= 1'b0;
      oct_bad_reg <= 4'h0;
      chr_valid_reg <= 1'b0;
      chr_data_reg <= 8'h00;
      chr_col_reg <= 7'h00;
      chr_bad_reg <= 1'b0;
      word_valid_reg <= 1'b0;
      word_data_reg <= 32'h00000000;
      word_addr_reg <= 24'h000000;
      word_bad_reg <= 1'b0;
    end else begin
      // drop accepted outputs
      if (chr_valid_reg && chr_ready)
        chr_valid_reg <= 1'b0;
      if (word_valid_reg && word_ready)
        word_valid_reg <= 1'b0;
      case (state_reg)
        ST_LOAD: begin
          if (row_valid && row_ready) begin
            if (row_cnt_reg == 4'h0)
              mode_reg <= card_mode;
            if (row_cnt_reg == `PCRD_LAST_ROW) begin
              row_cnt_reg <= 4'h0;
              state_reg <= ST_CHAR;
              // text cards show info columns, others only the id field
              col_reg <= (((row_cnt_reg == 4'h0) ? card_mode : mode_reg) == `PCRD_MODE_TEXT) ?
                         `PCRD_INFO_FIRST : `PCRD_ID_FIRST;
            end else begin
              row_cnt_reg <= row_cnt_reg + 4'h1;
            end
          end
        end
        ST_CHAR: begin
          if (chr_free) begin
            chr_valid_reg <= 1'b1;
            chr_data_reg <= dec_chr;
            chr_bad_reg <= dec_bad;
            chr_col_reg <= col_reg;
            if (col_reg == `PCRD_INFO_LAST || (mode_reg != `PCRD_MODE_TEXT && col_reg == `PCRD_ID_LAST)) begin
              wcnt_reg <= 5'h00;
              dig_cnt_reg <= 4'h0;
              loc_reg <= 24'h000000;
              acc_reg <= 32'h00000000;
              acc_bad_reg <= 1'b0;
              if (mode_reg == `PCRD_MODE_BIN) begin
                state_reg <= ST_WORD;
              end else if (mode_reg == `PCRD_MODE_OCT) begin
                state_reg <= ST_OCT;
                col_reg <= `PCRD_INFO_FIRST;
              end else begin
                state_reg <= ST_LOAD;
              end
            end else begin
              col_reg <= col_reg + 7'h01;
            end
          end
        end
        ST_OCT: begin
          // first eight info columns: location digits
          if (col_reg <= `PCRD_OCT_CTRL_LAST) begin
            loc_reg <= {loc_reg[20:0], dig};
          end else if (dig_cnt_reg == `PCRD_OCT_LAST_DIGIT) begin
            // eleven digits close one word
            oct_bad_reg[wcnt_reg[1:0]] <= acc_bad_reg || !dig_ok;
            acc_reg <= 32'h00000000;
            acc_bad_reg <= 1'b0;
            dig_cnt_reg <= 4'h0;
            wcnt_reg <= wcnt_reg + 5'h01;
          end else begin
            acc_reg <= {acc_reg[28:0], dig};
            // leading digit carries one bit only
            acc_bad_reg <= acc_bad_reg || !dig_ok || (dig_cnt_reg == 4'h0 && dig > 3'h1);
            dig_cnt_reg <= dig_cnt_reg + 4'h1;
          end
          if (col_reg == `PCRD_OCT_LAST_COL) begin
            state_reg <= ST_WORD;
            wcnt_reg <= 5'h00;
          end else begin
            col_reg <= col_reg + 7'h01;
          end
        end
        ST_WORD: begin
          // words wait until the last id character is taken, so the two never overlap
          if (word_free && chr_free) begin
            word_valid_reg <= 1'b1;
            if (mode_reg == `PCRD_MODE_BIN) begin
              // even count left half, odd count right half
              word_data_reg <= wcnt_reg[0] ? card_mem[wcnt_reg[4:1]][31:0] : card_mem[wcnt_reg[4:1]][63:32];
              word_addr_reg <= {19'h00000, wcnt_reg};
              word_bad_reg <= 1'b0;
            end else begin
              word_data_reg <= oct_mem[wcnt_reg[1:0]];
              word_addr_reg <= loc_reg + {19'h00000, wcnt_reg};
              word_bad_reg <= oct_bad_reg[wcnt_reg[1:0]];
            end
            if (wcnt_reg == ((mode_reg == `PCRD_MODE_BIN) ? `PCRD_BIN_LAST_WORD : `PCRD_OCT_LAST_WORD)) begin
              state_reg <= ST_LOAD;
              wcnt_reg <= 5'h00;
            end else begin
              wcnt_reg <= wcnt_reg + 5'h01;
            end
          end
        end
        default: begin
          state_reg <= ST_LOAD;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> sim/pcrd_decoder_sva.sv
// port assertions for the card row decoder
`timescale 1ns/100ps
`default_nettype none
module pcrd_decoder_sva (
  input wire logic clk,
  input wire logic srst,
  input wire logic row_valid,
  input wire logic row_ready,
  input wire logic chr_valid_reg,
  input wire logic chr_ready,
  input wire logic [7:0] chr_data_reg,
  input wire logic [6:0] chr_col_reg,
  input wire logic chr_bad_reg,
  input wire logic word_valid_reg,
  input wire logic word_ready,
  input wire logic [31:0] word_data_reg,
  input wire logic [23:0] word_addr_reg,
  input wire logic card_busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // ----------
  // rows taken of the current card
  // ----------
  logic [3:0] rows_reg;
  always_ff @(posedge clk) begin
    if (srst || (row_valid && row_ready && rows_reg == 4'hB)) begin
      rows_reg <= 4'h0;
    end else if (row_valid && row_ready) begin
      rows_reg <= rows_reg + 4'h1;
    end
  end
  // ----------
  // properties
  // ----------
  property p_twelve; row_valid && row_ready && rows_reg == 4'hB |=> !row_ready && card_busy; endproperty
  a_twelve: assert property (p_twelve) else $error("row taken after a full card");
  property p_ready; row_ready != card_busy; endproperty
  a_ready: assert property (p_ready) else $error("ready and busy disagree");
  property p_chr_hold;
    chr_valid_reg && !chr_ready |=> chr_valid_reg && $stable({chr_data_reg, chr_col_reg});
  endproperty
  a_chr_hold: assert property (p_chr_hold) else $error("character dropped");
  property p_word_hold;
    word_valid_reg && !word_ready |=> word_valid_reg && $stable({word_data_reg, word_addr_reg});
  endproperty
  a_word_hold: assert property (p_word_hold) else $error("word dropped");
  property p_chr_next; chr_valid_reg && chr_ready ##1 chr_valid_reg |-> chr_col_reg == $past(chr_col_reg) + 7'h1; endproperty
  a_chr_next: assert property (p_chr_next) else $error("column skipped");
  property p_word_next;
    word_valid_reg && word_ready ##1 word_valid_reg |-> word_addr_reg == $past(word_addr_reg) + 24'h1;
  endproperty
  a_word_next: assert property (p_word_next) else $error("word order broken");
  property p_bad_blank; chr_valid_reg && chr_bad_reg |-> chr_data_reg == 8'h20; endproperty
  a_bad_blank: assert property (p_bad_blank) else $error("bad column not blank");
  property p_no_overlap; chr_valid_reg |-> !word_valid_reg; endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("char and word together");
  property p_idle; row_ready |-> !chr_valid_reg && !word_valid_reg; endproperty
  a_idle: assert property (p_idle) else $error("output while loading");
endmodule
`default_nettype wire

// >>> sim/pcrd_card_src.sv
// card machine model offering the twelve rows of one card
`timescale 1ns/100ps
`default_nettype none
module pcrd_card_src (
  input wire logic clk,
  input wire logic srst,
  input wire logic start,
  input wire logic slow,
  input wire logic [959:0] card_img,
  input wire logic row_ready,
  output logic row_valid,
  output logic [79:0] row_data,
  output logic done
);
  int idx = 12; // next row to offer, 12 when idle
  initial begin
    row_valid = 1'b0;
    row_data = '0;
  end
  // row held until taken, released lines show the inverse
  always @(posedge clk) begin
    if (srst) begin
      row_valid <= 1'b0;
      idx <= 12;
    end else if (start) begin
      idx <= 0;
    end else if (row_valid && row_ready) begin
      idx <= idx + 1;
      row_valid <= idx < 11 && !slow;
      row_data <= (idx < 11 && !slow) ? card_img[(idx + 1) * 80 +: 80] : ~row_data;
    end else if (!row_valid && idx < 12 && !(slow && $urandom_range(1))) begin
      row_valid <= 1'b1;
      row_data <= card_img[idx * 80 +: 80]; // 9-row first, 12-row last
    end
  end
  assign done = (idx == 12);
endmodule
`default_nettype wire

// >>> sim/pcrd_decoder_test.sv
// self-checking bench for the card row decoder
`timescale 1ns/100ps
`default_nettype none
module pcrd_decoder_test;
  logic clk = 1'b0, srst = 1'b1, start = 1'b0, slow = 1'b0, chr_ready = 1'b0, word_ready = 1'b0;
  logic [1:0] card_mode = 2'h0;
  logic [959:0] img = '0;
  wire row_valid, row_ready, chr_valid_reg, chr_bad_reg, word_valid_reg, word_bad_reg, card_busy, done;
  wire [79:0] row_data;
  wire [7:0] chr_data_reg;
  wire [6:0] chr_col_reg;
  wire [31:0] word_data_reg;
  wire [23:0] word_addr_reg;
  int n_errors = 0, compares = 0;
  logic [15:0] cq[$]; // expected {char, column, bad}
  logic [56:0] wq[$]; // expected {word, address, bad}
  localparam logic [11:0] sp_p [8] = '{12'h800, 12'h400, 12'h042, 12'h442, 12'h242, 12'h022, 12'h422, 12'h222};
  localparam logic [7:0] sp_c [8] = '{8'h2B, 8'h2D, 8'h2B, 8'h24, 8'h2C, 8'h2D, 8'h2A, 8'h25};
  initial forever #2.5 clk = ~clk;
  pcrd_card_src pcrd_card_src_i (.clk(clk), .srst(srst), .start(start), .slow(slow), .card_img(img),
    .row_ready(row_ready), .row_valid(row_valid), .row_data(row_data), .done(done));
  pcrd_decoder pcrd_decoder_i (.clk(clk), .srst(srst), .row_valid(row_valid), .row_ready(row_ready),
    .row_data(row_data), .card_mode(card_mode), .chr_valid_reg(chr_valid_reg), .chr_ready(chr_ready),
    .chr_data_reg(chr_data_reg), .chr_col_reg(chr_col_reg), .chr_bad_reg(chr_bad_reg),
    .word_valid_reg(word_valid_reg), .word_ready(word_ready), .word_data_reg(word_data_reg),
    .word_addr_reg(word_addr_reg), .word_bad_reg(word_bad_reg), .card_busy(card_busy));
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // row bit of a lone numeric punch, zero in the 0-row
  function automatic logic [11:0] dpos(input int d);
    return 12'h001 << (d == 0 ? 9 : 9 - d);
  endfunction
  task automatic put_col(input int c, input logic [11:0] p);
    for (int k = 0; k < 12; k++) img[k * 80 + 80 - c] = p[k]; // punched reads one
  endtask
  // identification digits in columns 1..16
  task automatic id_field;
    int d;
    for (int c = 1; c <= 16; c++) begin
      d = $urandom_range(9);
      put_col(c, dpos(d));
      cq.push_back({8'(8'h30 + d), 7'(c), 1'b0});
    end
  endtask
  // offer one card and wait for all its results
  task automatic run_card(input logic [1:0] m, input logic s);
    int n;
    @(posedge clk);
    card_mode <= m;
    slow <= s;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    for (n = 0; n < 3000 && (cq.size() > 0 || wq.size() > 0 || card_busy !== 1'b0 || !done); n++) begin
      @(posedge clk);
      chr_ready <= !s || $urandom_range(1);
      word_ready <= !s || $urandom_range(1);
    end
    if (n == 3000) begin
      n_errors++;
      print_verdict();
    end
  endtask
  // results taken off the queues as they are handed over
  always @(posedge clk) begin
    if (!srst && chr_valid_reg === 1'b1 && chr_ready) begin
      check({chr_data_reg, chr_col_reg, chr_bad_reg}, cq.size() ? cq.pop_front() : 16'h0000);
    end
    if (!srst && word_valid_reg === 1'b1 && word_ready) begin
      check({word_data_reg, word_addr_reg, word_bad_reg}, wq.size() ? wq.pop_front() : 57'h0);
    end
  end
  initial begin
    logic [11:0] p;
    logic [7:0] ch;
    logic [79:0] row;
    logic [31:0] w;
    logic [23:0] loc;
    int d;
    void'($urandom(32'h0C05));
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    // text card: digits, letters of all zones, specials, blank, bad
    for (int i = 0; i < 64; i++) begin
      d = (i - 10) % 9 + 1;
      p = i < 10 ? dpos(i) : i < 37 ? (i < 19 ? 12'h800 : i < 28 ? 12'h400 : 12'h200) | dpos(d) :
          i < 45 ? sp_p[i - 37] : i == 45 ? 12'h000 : i == 46 ? 12'hC00 : dpos(i % 9 + 1);
      ch = i < 10 ? 8'(8'h30 + i) : i < 19 ? 8'(8'h40 + d) : i < 28 ? 8'(8'h49 + d) : i == 28 ? 8'h2F :
           i < 37 ? 8'(8'h51 + d) : i < 45 ? sp_c[i - 37] : i < 47 ? 8'h20 : 8'(8'h31 + i % 9);
      put_col(17 + i, p);
      cq.push_back({ch, 7'(17 + i), i == 46});
    end
    run_card(2'h0, 1'b0);
    $display("text card done");
    // binary cards: raw rows, 9-row control words still delivered
    for (int r = 0; r < 2; r++) begin
      for (int j = 0; j < 30; j++) img[j * 32 +: 32] = $urandom;
      id_field();
      for (int k = 0; k < 12; k++) begin
        row = img[k * 80 +: 80];
        wq.push_back({row[63:32], 24'(2 * k), 1'b0});
        wq.push_back({row[31:0], 24'(2 * k + 1), 1'b0});
      end
      run_card(2'h1, r == 0);
      $display("binary card done");
    end
    // octonary card: location then four words, one with a non-octal column
    img = '0;
    id_field();
    loc = '0;
    for (int c = 17; c <= 24; c++) begin
      d = $urandom_range(7);
      put_col(c, dpos(d));
      loc = loc * 8 + 24'(d);
    end
    for (int k = 0; k < 4; k++) begin
      w = '0;
      for (int j = 0; j < 11; j++) begin
        d = (k == 2 && j == 10) ? 8 : (j == 0) ? $urandom_range(1) : $urandom_range(7);
        put_col(25 + 11 * k + j, dpos(d));
        w = w * 8 + 32'(d & 7);
      end
      wq.push_back({w, loc + 24'(k), k == 2});
    end
    run_card(2'h2, 1'b1);
    $display("octonary card done");
    print_verdict();
  end
endmodule
bind pcrd_decoder pcrd_decoder_sva pcrd_decoder_sva_i (.clk(clk), .srst(srst), .row_valid(row_valid),
  .row_ready(row_ready), .chr_valid_reg(chr_valid_reg), .chr_ready(chr_ready), .chr_data_reg(chr_data_reg),
  .chr_col_reg(chr_col_reg), .chr_bad_reg(chr_bad_reg), .word_valid_reg(word_valid_reg),
  .word_ready(word_ready), .word_data_reg(word_data_reg), .word_addr_reg(word_addr_reg), .card_busy(card_busy));
`default_nettype wire
